/* File: design/mwtc_delta_mem.sv */
// storage for the delta words that follow the first one
`timescale 1ns/10ps

module mwtc_delta_mem #(
  parameter int unsigned DEPTH = 7,
  parameter int unsigned IDX_W = 3
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wrEn,
  input  wire logic [IDX_W-1:0]  wrIdx,
  input  wire logic [31:0]       wrData,
  input  wire logic [IDX_W-1:0]  rdIdx,
  output logic      [31:0]       rdData
);

  if (DEPTH < 1 || DEPTH > (1 << IDX_W)) begin : g_chk
    $error("mwtc_delta_mem: DEPTH does not fit IDX_W");
  end

  logic [31:0] words [DEPTH];

  // ----------------------------------------------------------------
  // entries
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        words[i] <= 32'h0000_0000;
      end else if (wrEn && wrIdx == IDX_W'(i)) begin
        words[i] <= wrData;
      end
    end
  end

  // registered read; out-of-range index reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h0000_0000;
    end else if (rdIdx < IDX_W'(DEPTH)) begin
      rdData <= words[rdIdx];
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

endmodule

/* File: design/mwtc_pkg.sv */
// shared constants for the microstep wave table configuration block
package mwtc_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] ADDR_START  = 8'h88;
  localparam logic [7:0] ADDR_SELECT = 8'h89;
  localparam logic [7:0] ADDR_DELTA0 = 8'h8a;
  localparam logic [7:0] ADDR_STATUS = 8'h90;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned START_A_LSB  = 0;
  localparam int unsigned START_B_LSB  = 16;
  localparam int unsigned OFFSET_B_LSB = 24;
  localparam int unsigned BORDER1_LSB  = 8;
  localparam int unsigned BORDER2_LSB  = 16;
  localparam int unsigned BORDER3_LSB  = 24;
  localparam int unsigned WCODE_W      = 2;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_A_LSB   = 8;
  localparam int unsigned STAT_B_LSB   = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_START_A  = 8'h00;
  localparam logic [7:0]  RST_START_B  = 8'hf7;
  localparam logic [7:0]  RST_OFFSET_B = 8'h00;
  localparam logic [7:0]  RST_BORDER1  = 8'h80;
  localparam logic [7:0]  RST_BORDER2  = 8'hff;
  localparam logic [7:0]  RST_BORDER3  = 8'hff;
  localparam logic [7:0]  RST_WCODES   = 8'h56;
  localparam logic [31:0] RST_DELTA0   = 32'haaaa_b554;

  // ----------------------------------------------------------------
  // table geometry
  // ----------------------------------------------------------------
  localparam int unsigned ENTRY_W     = 8;
  localparam int unsigned WORD_BITS   = 32;
  localparam int unsigned WORDS       = 8;
  localparam int unsigned BITSEL_W    = 5;
  localparam int unsigned ACC_W       = 11;
  localparam logic [8:0]  PEAK_ENTRY  = 9'h100;
  localparam logic [7:0]  LAST_ENTRY  = 8'hff;
  localparam logic [7:0]  CUR_MAX     = 8'hff;

  typedef enum logic [2:0] {
    MWTC_IDLE,
    MWTC_LOAD_A,
    MWTC_WALK_A,
    MWTC_LOAD_B,
    MWTC_WALK_B,
    MWTC_DONE
  } mwtc_state_t;

endpackage

/* File: design/mwtc_wave_config.sv */
// wave table configuration registers and table walk engine
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

// Operation
// - table splits into four segments by borders 1..3, last ends at 255.
// - width code and delta bit choose increment -1..+2 or 0..+3.
// - width codes of segments 0..3 sit in select bits 1:0..7:6.
// - borders 1,2,3 sit in select bits 15:8, 23:16, 31:24.
// - coil A start field bits 7:0 is current at entry zero.
// - coil B start field bits 23:16 is current at entry 256.
// - signed bits 31:24 shift coil B phase by -128..+127 microsteps.
// - each delta bit steps entry x to x+1 via segment of x.
// - delta bits ascend over entries 0..255 across words, quarter wave only.
// - start values load when microstep position counter and coil B offset are both zero.
module mwtc_wave_config (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  input  wire logic        deltaWrEn,
  input  wire logic [2:0]  deltaWrIdx,
  input  wire logic [31:0] deltaWrData,
  input  wire logic        lookupStart,
  input  wire logic [7:0]  microstepPos,
  output logic             lookupBusy,
  output logic             lookupDone,
  output logic      [7:0]  coilACurrent,
  output logic      [7:0]  coilBCurrent
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0]  startA_reg;
  logic [7:0]  startB_reg;
  logic [7:0]  offsetB_reg;
  logic [31:0] select_reg;
  logic [31:0] delta0_reg;

  wire hitStart  = regAddr == mwtc_pkg::ADDR_START;
  wire hitSelect = regAddr == mwtc_pkg::ADDR_SELECT;
  wire hitDelta0 = regAddr == mwtc_pkg::ADDR_DELTA0;
  wire hitStatus = regAddr == mwtc_pkg::ADDR_STATUS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startA_reg  <= mwtc_pkg::RST_START_A;
      startB_reg  <= mwtc_pkg::RST_START_B;
      offsetB_reg <= mwtc_pkg::RST_OFFSET_B;
    end else if (regWrite && hitStart) begin
      startA_reg  <= regWrData[mwtc_pkg::START_A_LSB +: 8];
      startB_reg  <= regWrData[mwtc_pkg::START_B_LSB +: 8];
      offsetB_reg <= regWrData[mwtc_pkg::OFFSET_B_LSB +: 8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_reg <= {mwtc_pkg::RST_BORDER3, mwtc_pkg::RST_BORDER2,
                     mwtc_pkg::RST_BORDER1, mwtc_pkg::RST_WCODES};
    end else if (regWrite && hitSelect) begin
      select_reg <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delta0_reg <= mwtc_pkg::RST_DELTA0;
    end else if (regWrite && hitDelta0) begin
      delta0_reg <= regWrData;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [7:0] border1 = select_reg[mwtc_pkg::BORDER1_LSB +: 8];
  wire [7:0] border2 = select_reg[mwtc_pkg::BORDER2_LSB +: 8];
  wire [7:0] border3 = select_reg[mwtc_pkg::BORDER3_LSB +: 8];
  wire [7:0] wcodes  = select_reg[7:0];

  // ----------------------------------------------------------------
  // walk engine
  // ----------------------------------------------------------------
  mwtc_pkg::mwtc_state_t state_reg, state_next;
  logic [8:0]  entry_reg, entry_next;
  logic [8:0]  target_reg, target_next;
  logic signed [mwtc_pkg::ACC_W-1:0] acc_reg, acc_next;
  logic [7:0]  coilA_reg, coilA_next;
  logic [7:0]  coilB_reg, coilB_next;
  logic [7:0]  posB_reg, posB_next;
  // coil A result parked until coil B is ready, so both currents change together
  logic [7:0]  holdA_reg, holdA_next;
  logic        word0Sel_reg;

  // entry currently walked; walk B and its word fetch go downward and use entry-1
  wire       walkDown = (state_reg == mwtc_pkg::MWTC_WALK_B) ||
                        (state_reg == mwtc_pkg::MWTC_LOAD_B);
  wire [7:0] curEntry = walkDown ? 8'(entry_reg - 9'd1) : entry_reg[7:0];
  wire [2:0] wordIdx  = curEntry[7:mwtc_pkg::BITSEL_W];
  wire [4:0] bitIdx   = curEntry[mwtc_pkg::BITSEL_W-1:0];

  logic [31:0] memRdData;

  mwtc_delta_mem #(
    .DEPTH (mwtc_pkg::WORDS - 1),
    .IDX_W (3)
  ) u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (deltaWrEn && deltaWrIdx != 3'd0),
    .wrIdx  (3'(deltaWrIdx - 3'd1)),
    .wrData (deltaWrData),
    .rdIdx  (3'(wordIdx - 3'd1)),
    .rdData (memRdData)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word0Sel_reg <= 1'b0;
    end else begin
      word0Sel_reg <= wordIdx == 3'd0;
    end
  end

  wire [31:0] curWord  = word0Sel_reg ? delta0_reg : memRdData;
  wire        deltaBit = curWord[bitIdx];

  // segment of the lower entry of the step being taken
  wire [1:0] segment = (curEntry >= border3) ? 2'd3 :
                       (curEntry >= border2) ? 2'd2 :
                       (curEntry >= border1) ? 2'd1 : 2'd0;
  wire [1:0] wcode   = wcodes[segment*mwtc_pkg::WCODE_W +: mwtc_pkg::WCODE_W];

  // code + bit - 1 covers both increment columns
  wire signed [mwtc_pkg::ACC_W-1:0] increment =
    $signed({{(mwtc_pkg::ACC_W-2){1'b0}}, wcode}) +
    $signed({{(mwtc_pkg::ACC_W-1){1'b0}}, deltaBit}) -
    $signed(mwtc_pkg::ACC_W'(1));

  // phase shifted coil B position, clamped into the quarter
  wire signed [9:0] posBRaw = $signed({2'b00, microstepPos}) +
                              $signed({{2{offsetB_reg[7]}}, offsetB_reg});
  wire [7:0] posBClamp = posBRaw[9] ? 8'h00 :
                         posBRaw[8] ? mwtc_pkg::LAST_ENTRY : posBRaw[7:0];

  // saturation of the accumulator onto an 8-bit current
  wire [7:0] accSat = acc_reg[mwtc_pkg::ACC_W-1] ? 8'h00 :
                      (acc_reg > $signed({3'b000, mwtc_pkg::CUR_MAX})) ?
                      mwtc_pkg::CUR_MAX : acc_reg[7:0];

  wire wordEdgeA = bitIdx == 5'd31;
  wire wordEdgeB = bitIdx == 5'd0;

  always_comb begin
    state_next  = state_reg;
    entry_next  = entry_reg;
    target_next = target_reg;
    acc_next    = acc_reg;
    coilA_next  = coilA_reg;
    coilB_next  = coilB_reg;
    posB_next   = posB_reg;
    holdA_next  = holdA_reg;
    case (state_reg)
      mwtc_pkg::MWTC_IDLE: begin
        if (lookupStart) begin
          posB_next = posBClamp;
          if (microstepPos == 8'h00 && offsetB_reg == 8'h00) begin
            coilA_next = startA_reg;
            coilB_next = startB_reg;
            state_next = mwtc_pkg::MWTC_DONE;
          end else begin
            entry_next  = 9'd0;
            target_next = {1'b0, microstepPos};
            acc_next    = $signed({3'b000, startA_reg});
            state_next  = mwtc_pkg::MWTC_LOAD_A;
          end
        end
      end
      mwtc_pkg::MWTC_LOAD_A: begin
        state_next = mwtc_pkg::MWTC_WALK_A;
      end
      mwtc_pkg::MWTC_WALK_A: begin
        if (entry_reg == target_reg) begin
          holdA_next  = accSat;
          entry_next  = mwtc_pkg::PEAK_ENTRY;
          target_next = {1'b0, posB_reg};
          acc_next    = $signed({3'b000, startB_reg});
          state_next  = mwtc_pkg::MWTC_LOAD_B;
        end else begin
          acc_next   = acc_reg + increment;
          entry_next = 9'(entry_reg + 9'd1);
          if (wordEdgeA) begin
            state_next = mwtc_pkg::MWTC_LOAD_A;
          end
        end
      end
      mwtc_pkg::MWTC_LOAD_B: begin
        state_next = mwtc_pkg::MWTC_WALK_B;
      end
      mwtc_pkg::MWTC_WALK_B: begin
        // coil B runs the mirrored quarter down from its peak
        if (entry_reg == 9'(mwtc_pkg::PEAK_ENTRY - target_reg)) begin
          coilA_next = holdA_reg;
          coilB_next = accSat;
          state_next = mwtc_pkg::MWTC_DONE;
        end else begin
          acc_next   = acc_reg - increment;
          entry_next = 9'(entry_reg - 9'd1);
          if (wordEdgeB) begin
            state_next = mwtc_pkg::MWTC_LOAD_B;
          end
        end
      end
      mwtc_pkg::MWTC_DONE: begin
        state_next = mwtc_pkg::MWTC_IDLE;
      end
      default: begin
        state_next = mwtc_pkg::MWTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= mwtc_pkg::MWTC_IDLE;
      entry_reg  <= 9'd0;
      target_reg <= 9'd0;
      acc_reg    <= '0;
      posB_reg   <= 8'h00;
      holdA_reg  <= mwtc_pkg::RST_START_A;
    end else begin
      state_reg  <= state_next;
      entry_reg  <= entry_next;
      target_reg <= target_next;
      acc_reg    <= acc_next;
      posB_reg   <= posB_next;
      holdA_reg  <= holdA_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coilA_reg <= mwtc_pkg::RST_START_A;
      coilB_reg <= mwtc_pkg::RST_START_B;
    end else begin
      coilA_reg <= coilA_next;
      coilB_reg <= coilB_next;
    end
  end

  // ----------------------------------------------------------------
  // handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lookupBusy <= 1'b0;
      lookupDone <= 1'b0;
    end else begin
      lookupBusy <= state_next != mwtc_pkg::MWTC_IDLE;
      lookupDone <= state_next == mwtc_pkg::MWTC_DONE;
    end
  end

  assign coilACurrent = coilA_reg;
  assign coilBCurrent = coilB_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {8'h00, coilB_reg, coilA_reg, 7'h00, lookupBusy};
  wire [31:0] readMux =
    hitStart  ? {offsetB_reg, startB_reg, 8'h00, startA_reg} :
    hitSelect ? select_reg :
    hitDelta0 ? delta0_reg :
    hitStatus ? statusWord : 32'h0000_0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      regRdData <= readMux;
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule

/* File: dv/mwtc_wave_config_assertions.sv */
// concurrent property checker for the wave table configuration block
`timescale 1ns/10ps
module mwtc_wave_config_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  input wire logic        lookupStart,
  input wire logic [7:0]  microstepPos,
  input wire logic        lookupBusy,
  input wire logic        lookupDone,
  input wire logic [7:0]  coilACurrent,
  input wire logic [7:0]  coilBCurrent
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic [31:0] startReg;
  wire         mapped = regAddr inside {mwtc_pkg::ADDR_START, mwtc_pkg::ADDR_SELECT,
                                        mwtc_pkg::ADDR_DELTA0, mwtc_pkg::ADDR_STATUS};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) startReg <= 32'h00f7_0000;
    else if (regWrite && regAddr == mwtc_pkg::ADDR_START) startReg <= regWrData;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property pBack(logic [7:0] a, logic [31:0] m);
    regWrite && regAddr == a ##2 regRead && regAddr == a |=> regRdData == ($past(regWrData, 3) & m);
  endproperty
  chk_sel_readback: assert property (pBack(mwtc_pkg::ADDR_SELECT, 32'hffff_ffff))
    else $error("select word not read back");
  chk_start_readback: assert property (pBack(mwtc_pkg::ADDR_START, 32'hffff_00ff))
    else $error("start word not read back");
  chk_delta_readback: assert property (pBack(mwtc_pkg::ADDR_DELTA0, 32'hffff_ffff))
    else $error("first delta word not read back");
  chk_rd_one_cycle: assert property (!$past(regRead) |-> regRdData == 32'h0000_0000)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property (regRead && !mapped |=> regRdData == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_zero_quick: assert property (lookupStart && !lookupBusy && microstepPos == 8'h00 &&
    startReg[31:24] == 8'h00 |-> ##[1:2] (lookupDone && coilACurrent == startReg[7:0] &&
    coilBCurrent == startReg[23:16])) else $error("start values not loaded at position zero");
  chk_done_pulse: assert property (lookupDone |=> !lookupDone)
    else $error("done longer than one cycle");
  chk_busy_start: assert property (lookupStart && !lookupBusy |=> lookupBusy)
    else $error("busy not raised by start");
  chk_busy_fall: assert property ($fell(lookupBusy) |-> $past(lookupDone))
    else $error("busy dropped without done");
  chk_result_hold: assert property (!lookupDone |-> $stable(coilACurrent) &&
    $stable(coilBCurrent)) else $error("currents changed without a result");
  cover property (lookupDone && lookupBusy);
  cover property ($fell(lookupBusy) ##1 lookupStart);
  cover property (regRead && !mapped);
endmodule

bind mwtc_wave_config mwtc_wave_config_chk i_mwtc_wave_config_chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .lookupStart(lookupStart),
  .microstepPos(microstepPos), .lookupBusy(lookupBusy), .lookupDone(lookupDone),
  .coilACurrent(coilACurrent), .coilBCurrent(coilBCurrent));

/* File: dv/mwtc_wave_config_tb.sv */
// self-checking bench for the wave table configuration block
`timescale 1ns/10ps
module mwtc_wave_config_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic        deltaWrEn = 1'b0;
  logic [2:0]  deltaWrIdx = 3'h0;
  logic [31:0] deltaWrData = 32'h0000_0000;
  logic        lookupStart = 1'b0;
  logic [7:0]  microstepPos = 8'h00;
  logic        lookupBusy;
  logic        lookupDone;
  logic [7:0]  coilACurrent;
  logic [7:0]  coilBCurrent;
  logic [31:0] rdQ[$];
  logic [15:0] lkQ[$];
  logic        rdPend = 1'b0;
  logic [31:0] seed = 32'h0000_0bf5;
  logic [31:0] startV = 32'h00f7_0000;
  logic [31:0] selV = 32'hffff_8056;
  logic [31:0] dw[8];
  logic [15:0] lastAB;
  // pos and signed offset pairs: word and segment edges, clamps
  logic [15:0] cases[11] = '{16'h0000, 16'h0100, 16'h0700, 16'h0800, 16'h1f00, 16'h2000,
                             16'hff00, 16'hc87f, 16'h0a81, 16'h64fb, 16'h0005};
  int          err_total = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  mwtc_wave_config i_mwtc_wave_config (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .deltaWrEn(deltaWrEn), .deltaWrIdx(deltaWrIdx),
    .deltaWrData(deltaWrData), .lookupStart(lookupStart), .microstepPos(microstepPos),
    .lookupBusy(lookupBusy), .lookupDone(lookupDone), .coilACurrent(coilACurrent),
    .coilBCurrent(coilBCurrent));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    return seed;
  endfunction

  function automatic int incr(int x);
    int c;
    c = x < selV[15:8] ? selV[1:0] : x < selV[23:16] ? selV[3:2] :
        x < selV[31:24] ? selV[5:4] : selV[7:6];
    return c + dw[x / 32][x % 32] - 1;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    if (a == mwtc_pkg::ADDR_START) startV = d;
    if (a == mwtc_pkg::ADDR_SELECT) selV = d;
    if (a == mwtc_pkg::ADDR_DELTA0) dw[0] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    rdQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask

  task automatic dwr(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk);
    deltaWrEn <= 1'b1;
    deltaWrIdx <= i;
    deltaWrData <= d;
    @(posedge clk);
    deltaWrEn <= 1'b0;
    if (i != 3'h0) dw[i] = d;
  endtask

  // coil A walks up from entry zero, coil B walks down from entry 256
  task automatic lk(input logic [7:0] pos, input bit again);
    int a, b, pb, n;
    a = startV[7:0];
    for (int x = 0; x < pos; x++) a += incr(x);
    pb = int'(pos) + int'($signed(startV[31:24]));
    pb = pb < 0 ? 0 : pb > 255 ? 255 : pb;
    b = startV[23:16];
    // coil B at shifted position p sits at mirrored entry 256 - p
    for (int x = 256 - pb; x < 256; x++) b -= incr(x);
    a = a < 0 ? 0 : a > 255 ? 255 : a;
    b = b < 0 ? 0 : b > 255 ? 255 : b;
    lastAB = {a[7:0], b[7:0]};
    lkQ.push_back(lastAB);
    @(posedge clk);
    microstepPos <= pos;
    lookupStart <= 1'b1;
    @(posedge clk);
    lookupStart <= 1'b0;
    // a second start while busy must be ignored
    if (again) begin
      repeat (3) @(posedge clk);
      lookupStart <= 1'b1;
      microstepPos <= ~pos;
      @(posedge clk);
      lookupStart <= 1'b0;
    end
    #1;
    for (n = 0; n < 2000 && lookupDone !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 2000) begin
      err_total++;
      $display("ERROR %0t: lookup never finished", $time);
      end_of_test();
    end
  endtask

  // ------------------------------------------------------------
  // monitor
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rdPend) chk(regRdData, rdQ.pop_front());
    rdPend <= regRead;
    if (lookupDone === 1'b1)
      chk({coilACurrent, coilBCurrent}, lkQ.pop_front());
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    for (int i = 0; i < 8; i++) dw[i] = 32'h0000_0000;
    dw[0] = mwtc_pkg::RST_DELTA0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(mwtc_pkg::ADDR_START, 32'h00f7_0000);
    rd(mwtc_pkg::ADDR_SELECT, 32'hffff_8056);
    rd(mwtc_pkg::ADDR_DELTA0, 32'haaaa_b554);
    rd(mwtc_pkg::ADDR_STATUS, 32'h00f7_0000);
    rd(8'h8b, 32'h0000_0000);
    lk(8'h00, 1'b0);
    lk(8'h28, 1'b1);
    dwr(3'h0, 32'hffff_ffff);
    rd(mwtc_pkg::ADDR_DELTA0, 32'haaaa_b554);
    wr(mwtc_pkg::ADDR_SELECT, 32'h1810_086c);
    rd(mwtc_pkg::ADDR_SELECT, 32'h1810_086c);
    wr(8'h8b, 32'hffff_ffff);
    rd(mwtc_pkg::ADDR_SELECT, 32'h1810_086c);
    for (int i = 1; i < 8; i++) dwr(i[2:0], rnd() & rnd());
    r = rnd();
    wr(mwtc_pkg::ADDR_DELTA0, r);
    rd(mwtc_pkg::ADDR_DELTA0, r);
    wr(mwtc_pkg::ADDR_START, 32'h00ff_5a40);
    rd(mwtc_pkg::ADDR_START, 32'h00ff_0040);
    foreach (cases[i]) begin
      wr(mwtc_pkg::ADDR_START, {cases[i][7:0], 24'hff_0040});
      lk(cases[i][15:8], cases[i][15:8] > 8'h40);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(mwtc_pkg::ADDR_START, {(r[7:0] == 8'h80) ? 8'h00 : r[7:0], 24'hff_0040});
      // a repeated start only where the walk outlasts it
      lk(r[15:8], r[16] && r[15:8] > 8'h40);
    end
    rd(mwtc_pkg::ADDR_STATUS, {8'h00, lastAB[7:0], lastAB[15:8], 8'h00});
    repeat (3) @(posedge clk);
    chk(rdQ.size() + lkQ.size(), 32'h0000_0000);
    end_of_test();
  end
endmodule
